// >>> hw/quadrature_decoder_pkg.sv
// Package for the quadrature position and velocity decoder.
// Assumes a single clock domain at 50 MHz.
`default_nettype none
package quadrature_decoder_pkg;
  localparam int POS_WIDTH       = 32;
  localparam int VEL_WIDTH       = 32;
  localparam int TIMER_WIDTH     = 32;
  localparam int SYNC_STAGES     = 2;
  localparam int EVT_COUNT       = 4;
  // Event bit positions in the status and mask vectors.
  localparam int EVT_INDEX       = 0;
  localparam int EVT_TIMER       = 1;
  localparam int EVT_DIR         = 2;
  localparam int EVT_ERROR       = 3;
  // Reset values.
  localparam logic [31:0] MAX_POS_RESET = 32'hffffffff;
  localparam logic [31:0] PERIOD_RESET  = 32'h0000c350;
  localparam logic        DIR_FORWARD   = 1'b0;
  localparam logic        DIR_REVERSE   = 1'b1;
endpackage
`default_nettype wire

// >>> hw/input_sync.sv
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes core_clk and an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module input_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  // Levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output var  logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = asyncIn;
    sync_d = meta_q;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= meta_d;
      syncOut <= sync_d;
    end
  end
endmodule // input_sync
`default_nettype wire

// >>> hw/quadrature_decoder.sv
// Quadrature/step-direction encoder decoder with position, velocity and events.
// Assumes encoder pins asynchronous, control bits static while enabled.
// How it works
// (R1) Decode two channels and index into an absolute or relative position count.
// (R2) Velocity is the pulse count within a fixed timer period.
// (R3) Velocity counter only accumulates while position decoding is enabled.
// (R4) Phase mode derives direction from the edge order of channels a and b.
// (R5) Step/direction mode: channel a steps the count, channel b gives direction.
// (R6) Phase mode counts edges of channel a only, or of both channels.
// (R7) Swap exchanges the two channel inputs before any decoding.
// (R8) With index reset on, each index pulse resets the position counter.
// (R9) With index reset off, index never touches the position counter.
// (R10) Timer marks equal periods; running and previous totals both readable.
// (R11) Events on index, timer expiry, direction change and phase error.
// (R12) Each event has its own mask; only unmasked events drive the interrupt.
// (R13) In phase mode, both channels changing in the same sample flags an error.
// (R14) Maximum position bounds count; reverse index loads the maximum.
// (R15) Direction status holds the last detected direction while stationary.
// (R16) Forward index clears position to zero; count wraps at zero and maximum.
// (R17) Channels and index are synchronised before edge detection.
`timescale 1ns/100ps
`default_nettype none
module quadrature_decoder #(
  parameter int POS_W = quadrature_decoder_pkg::POS_WIDTH,
  parameter int VEL_W = quadrature_decoder_pkg::VEL_WIDTH,
  parameter int TMR_W = quadrature_decoder_pkg::TIMER_WIDTH
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  // Encoder pins
  input  wire logic             chanA,
  input  wire logic             chanB,
  input  wire logic             indexIn,
  // Configuration
  input  wire logic             enable,
  input  wire logic             velEnable,
  input  wire logic             stepDirMode,
  input  wire logic             countBoth,
  input  wire logic             swapInputs,
  input  wire logic             indexReset,
  input  wire logic [POS_W-1:0] maxPosition,
  input  wire logic [TMR_W-1:0] velPeriod,
  input  wire logic             posLoad,
  input  wire logic [POS_W-1:0] posLoadValue,
  // Events
  input  wire logic [3:0]       eventMask,
  input  wire logic [3:0]       eventClear,
  output var  logic [3:0]       eventStatus,
  output var  logic             irq,
  // Status
  output var  logic [POS_W-1:0] position,
  output var  logic [VEL_W-1:0] velRunning,
  output var  logic [VEL_W-1:0] velPrevious,
  output var  logic             direction,
  output var  logic             phaseError
);
  // ---------------------------------------------------------------
  // Input synchronisation and edge detection
  // ---------------------------------------------------------------
  logic [2:0] pinSync;
  // The previous synchronised sample of each pin, for edge detection.
  logic [2:0] prev_q;
  logic [2:0] prev_d;

  input_sync #(.WIDTH(3)) u_sync ( // R17
    .core_clk (core_clk),
    .nrst     (nrst),
    .asyncIn  ({indexIn, chanB, chanA}),
    .syncOut  (pinSync)
  );

  logic curA;
  logic curB;
  logic oldA;
  logic oldB;
  logic chgA;
  logic chgB;
  logic idxRise;
  logic stepEvt;
  logic stepDir;
  logic badEvt;

  // Forward is channel b leading channel a: an edge of a that leaves the channels
  // equal, or an edge of b that leaves them different, counts up.
  always_comb begin
    prev_d  = pinSync;
    curA    = swapInputs ? pinSync[1] : pinSync[0]; // R7
    curB    = swapInputs ? pinSync[0] : pinSync[1]; // R7
    oldA    = swapInputs ? prev_q[1] : prev_q[0];
    oldB    = swapInputs ? prev_q[0] : prev_q[1];
    chgA    = curA ^ oldA;
    chgB    = curB ^ oldB;
    idxRise = pinSync[2] & ~prev_q[2];
    stepEvt = 1'b0;
    stepDir = direction;
    badEvt  = 1'b0;
    if (stepDirMode) begin
      stepEvt = curA & ~oldA; // R5
      stepDir = curB ? quadrature_decoder_pkg::DIR_REVERSE
                     : quadrature_decoder_pkg::DIR_FORWARD; // R5
    end else if (chgA && chgB) begin
      badEvt = 1'b1; // R13
    end else if (chgA) begin
      stepEvt = 1'b1; // R4 R6
      stepDir = (curA ^ curB) ? quadrature_decoder_pkg::DIR_REVERSE
                              : quadrature_decoder_pkg::DIR_FORWARD; // R4
    end else if (chgB) begin
      stepEvt = countBoth; // R6
      stepDir = (curA ^ curB) ? quadrature_decoder_pkg::DIR_FORWARD
                              : quadrature_decoder_pkg::DIR_REVERSE; // R4
    end
  end

  // ---------------------------------------------------------------
  // Position, direction and velocity
  // ---------------------------------------------------------------
  logic [POS_W-1:0] position_d;
  logic             direction_d;
  logic             dirChange;
  logic [VEL_W-1:0] velRunning_d;
  logic [VEL_W-1:0] velPrevious_d;
  logic [TMR_W-1:0] timer_q;
  logic [TMR_W-1:0] timer_d;
  logic             timerExpire;

  always_comb begin
    position_d    = position;
    direction_d   = direction;
    dirChange     = 1'b0;
    velRunning_d  = velRunning;
    velPrevious_d = velPrevious;
    timer_d       = timer_q;
    timerExpire   = 1'b0;
    // A load wins over counting in the same cycle.
    if (posLoad) begin
      position_d = posLoadValue;
    end else if (enable) begin // R1
      if (stepEvt) begin
        direction_d = stepDir; // R15
        dirChange   = (stepDir != direction);
        if (stepDir == quadrature_decoder_pkg::DIR_FORWARD) begin
          position_d = (position >= maxPosition) ? '0 : position + 1'b1; // R16
        end else begin
          position_d = (position == '0) ? maxPosition : position - 1'b1; // R16 R14
        end
      end
      // An index pulse on a stepping cycle is applied last, so the reset
      // value follows the direction of that step.
      if (idxRise && indexReset) begin // R8 R9
        position_d = (direction_d == quadrature_decoder_pkg::DIR_REVERSE)
                     ? maxPosition : '0; // R14 R16
      end
    end
    // The timer runs from zero to velPeriod, so one period lasts velPeriod + 1 cycles.
    // A pulse on the expiry cycle still belongs to the period that ends.
    if (enable && velEnable) begin // R3
      if (timer_q >= velPeriod) begin // R10
        timer_d       = '0;
        timerExpire   = 1'b1;
        velPrevious_d = velRunning + VEL_W'(stepEvt); // R2 R10
        velRunning_d  = '0;
      end else begin
        timer_d      = timer_q + 1'b1;
        velRunning_d = velRunning + VEL_W'(stepEvt); // R2
      end
    end else begin
      timer_d = '0;
    end
  end

  // ---------------------------------------------------------------
  // Events and interrupt
  // ---------------------------------------------------------------
  logic [3:0] eventSet;
  logic [3:0] eventStatus_d;
  logic       irq_d;
  logic       phaseError_d;

  always_comb begin
    eventSet = '0;
    eventSet[quadrature_decoder_pkg::EVT_INDEX] = enable & idxRise; // R11
    eventSet[quadrature_decoder_pkg::EVT_TIMER] = timerExpire; // R11
    eventSet[quadrature_decoder_pkg::EVT_DIR]   = enable & dirChange; // R11
    eventSet[quadrature_decoder_pkg::EVT_ERROR] = enable & badEvt; // R11 R13
    // A new event wins over a clear in the same cycle.
    eventStatus_d = (eventStatus & ~eventClear) | eventSet;
    // The interrupt uses the next status so it rises with the flag.
    irq_d         = |(eventStatus_d & eventMask); // R12
    // The error flag keeps the same set-over-clear order as the status bits.
    phaseError_d  = phaseError | (enable & badEvt); // R13
    if (eventClear[quadrature_decoder_pkg::EVT_ERROR] && !(enable && badEvt)) begin
      phaseError_d = 1'b0;
    end
  end

  // All state registers here, so every output comes straight from a flip-flop.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prev_q      <= '0;
      position    <= '0;
      direction   <= quadrature_decoder_pkg::DIR_FORWARD;
      velRunning  <= '0;
      velPrevious <= '0;
      timer_q     <= '0;
      eventStatus <= '0;
      irq         <= 1'b0;
      phaseError  <= 1'b0;
    end else begin
      prev_q      <= prev_d;
      position    <= position_d;
      direction   <= direction_d;
      velRunning  <= velRunning_d;
      velPrevious <= velPrevious_d;
      timer_q     <= timer_d;
      eventStatus <= eventStatus_d;
      irq         <= irq_d;
      phaseError  <= phaseError_d;
    end
  end
endmodule // quadrature_decoder
`default_nettype wire

// >>> bench/quadrature_decoder_assertions.sv
// Port assertions for the quadrature decoder.
// Bound to every quadrature_decoder instance.
`timescale 1ns/100ps
`default_nettype none
module quadrature_decoder_assertions #(
  parameter int POS_W = 32,
  parameter int VEL_W = 32
) (
  // Watched ports
  input wire logic             core_clk,
  input wire logic             nrst,
  input wire logic             enable,
  input wire logic             indexReset,
  input wire logic             posLoad,
  input wire logic [POS_W-1:0] maxPosition,
  input wire logic [3:0]       eventMask,
  input wire logic [3:0]       eventClear,
  input wire logic [3:0]       eventStatus,
  input wire logic             irq,
  input wire logic [POS_W-1:0] position,
  input wire logic [VEL_W-1:0] velRunning,
  input wire logic [VEL_W-1:0] velPrevious,
  input wire logic             direction,
  input wire logic             phaseError
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_irq; irq == |(eventStatus & $past(eventMask)); endproperty
  a_irq: assert property (p_irq) else $error("irq differs from masked status");
  property p_vel_hold; !$past(enable) |-> $stable(velRunning); endproperty
  a_vel_hold: assert property (p_vel_hold) else $error("velocity moved while off");
  property p_pos_hold; !$past(enable) && !$past(posLoad) |-> $stable(position); endproperty
  a_pos_hold: assert property (p_pos_hold) else $error("position moved while off");
  property p_bound; $changed(position) && !$past(posLoad) |-> position <= maxPosition; endproperty
  a_bound: assert property (p_bound) else $error("position above maximum");
  property p_dir_evt; $changed(direction) |-> eventStatus[2]; endproperty
  a_dir_evt: assert property (p_dir_evt) else $error("direction change without event");
  property p_err_keep; phaseError && !eventClear[3] |=> phaseError; endproperty
  a_err_keep: assert property (p_err_keep) else $error("phase error flag lost");
  property p_vel_prev; $changed(velPrevious) |-> eventStatus[1]; endproperty
  a_vel_prev: assert property (p_vel_prev) else $error("velocity latched without expiry");
  property p_step;
    $changed(position) && !$past(posLoad) && !$past(indexReset) |-> position == $past(position) + 1
      || position == $past(position) - 1 || position == 0 || position == maxPosition;
  endproperty
  a_step: assert property (p_step) else $error("position jumped");
endmodule // quadrature_decoder_assertions
bind quadrature_decoder quadrature_decoder_assertions #(.POS_W(POS_W), .VEL_W(VEL_W)) chk_inst (
  .core_clk(core_clk), .nrst(nrst), .enable(enable), .indexReset(indexReset),
  .posLoad(posLoad), .maxPosition(maxPosition), .eventMask(eventMask),
  .eventClear(eventClear), .eventStatus(eventStatus), .irq(irq), .position(position),
  .velRunning(velRunning), .velPrevious(velPrevious), .direction(direction),
  .phaseError(phaseError));
`default_nettype wire

// >>> bench/encoder_model.sv
// Behavioural encoder driving the decoder pins.
// Commands last one cycle: 1 forward, 3 reverse, 2 both channels at once.
`timescale 1ns/100ps
`default_nettype none
module encoder_model (
  // Control
  input  wire logic       core_clk,
  input  wire logic       stepDir,
  input  wire logic [1:0] cmd,
  input  wire logic       idx,
  // Pins
  output wire logic       chanA,
  output wire logic       chanB,
  output var  logic       indexIn
);
  logic [1:0] phase_q = 2'h0;
  logic       stepA_q = 1'b0;
  logic       dirB_q  = 1'b0;
  logic       pend_q  = 1'b0;
  // Phase steps are Gray coded with channel b leading channel a when moving forward.
  // In step mode the direction level settles a cycle before the step.
  always_ff @(posedge core_clk) begin
    indexIn <= idx;
    phase_q <= phase_q + cmd;
    pend_q  <= cmd != 2'h0;
    stepA_q <= pend_q;
    if (cmd != 2'h0) dirB_q <= cmd[1];
  end
  assign chanA = stepDir ? stepA_q : phase_q[1];
  assign chanB = stepDir ? dirB_q : phase_q[0] ^ phase_q[1];
endmodule // encoder_model
`default_nettype wire

// >>> bench/quadrature_position_velocity_bench.sv
// Self-checking bench for the quadrature decoder.
// Assumes the encoder model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module quadrature_position_velocity_bench;
  localparam logic [1:0] FWD = 2'h1, ERR = 2'h2, REV = 2'h3;
  logic        core_clk = 1'b0, nrst = 1'b0, enable = 1'b1, velEnable = 1'b0;
  logic        stepDirMode = 1'b0, countBoth = 1'b1, swapInputs = 1'b0, indexReset = 1'b0;
  logic        posLoad = 1'b0, idx = 1'b0, chanA, chanB, indexIn, irq, direction, phaseError;
  logic [1:0]  cmd = 2'h0;
  logic [3:0]  eventMask = 4'h0, eventClear = 4'h0, eventStatus;
  logic [31:0] position, velRunning, velPrevious;
  int          n_mismatch = 0, n_tests = 0;
  encoder_model encoder_model_inst (.core_clk, .stepDir(stepDirMode), .cmd, .idx, .chanA,
    .chanB, .indexIn);
  quadrature_decoder quadrature_decoder_inst (.core_clk, .nrst, .chanA, .chanB, .indexIn,
    .enable, .velEnable, .stepDirMode, .countBoth, .swapInputs, .indexReset,
    .maxPosition(32'h9), .velPeriod(32'h63), .posLoad, .posLoadValue(32'h4), .eventMask,
    .eventClear, .eventStatus, .irq, .position, .velRunning, .velPrevious, .direction,
    .phaseError);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic go(input logic [1:0] c, input int n);
    repeat (n) begin
      cmd <= c;
      @(posedge core_clk);
      cmd <= 2'h0;
      repeat (6) @(posedge core_clk);
    end
  endtask
  task automatic pulse_idx;
    idx <= 1'b1;
    @(posedge core_clk);
    idx <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic clr(input logic [3:0] m);
    eventClear <= m;
    @(posedge core_clk);
    eventClear <= 4'h0;
    @(posedge core_clk);
  endtask
  task automatic wait_timer;
    for (int i = 0; i < 300 && eventStatus[1] !== 1'b1; i++) @(posedge core_clk);
    chk("timer event", 32'h1, eventStatus[1]);
  endtask
  task automatic print_verdict;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial forever #10 core_clk = ~core_clk;
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    chk("position", 32'h0, position);
    go(FWD, 3);
    chk("position", 32'h3, position);
    chk("direction", quadrature_decoder_pkg::DIR_FORWARD, direction);
    go(REV, 5);
    chk("position", 32'h8, position);
    chk("dir event", 32'h1, eventStatus[2]);
    go(FWD, 2);
    chk("position", 32'h0, position);
    countBoth <= 1'b0;
    go(FWD, 4);
    chk("position", 32'h2, position);
    countBoth <= 1'b1;
    swapInputs <= 1'b1;
    go(FWD, 2);
    chk("position", 32'h0, position);
    chk("direction", quadrature_decoder_pkg::DIR_REVERSE, direction);
    swapInputs <= 1'b0;
    indexReset <= 1'b1;
    go(FWD, 1);
    pulse_idx();
    chk("position", 32'h0, position);
    chk("index event", 32'h1, eventStatus[0]);
    go(REV, 2);
    pulse_idx();
    chk("position", 32'h9, position);
    indexReset <= 1'b0;
    go(REV, 1);
    pulse_idx();
    chk("position", 32'h8, position);
    clr(4'hf);
    eventMask <= 4'h8;
    go(ERR, 1);
    chk("phase error", 32'h1, phaseError);
    chk("error event", 32'h1, eventStatus[3]);
    chk("irq", 32'h1, irq);
    eventMask <= 4'h1;
    repeat (2) @(posedge core_clk);
    chk("irq", 32'h0, irq);
    clr(4'h8);
    chk("phase error", 32'h0, phaseError);
    posLoad <= 1'b1;
    @(posedge core_clk);
    posLoad <= 1'b0;
    @(posedge core_clk);
    chk("position", 32'h4, position);
    velEnable <= 1'b1;
    wait_timer();
    clr(4'h2);
    go(FWD, 5);
    chk("running", 32'h5, velRunning);
    wait_timer();
    chk("previous", 32'h5, velPrevious);
    enable <= 1'b0;
    go(FWD, 3);
    chk("running", 32'h0, velRunning);
    chk("position", 32'h9, position);
    stepDirMode <= 1'b1;
    repeat (6) @(posedge core_clk);
    enable <= 1'b1;
    go(FWD, 2);
    go(REV, 1);
    chk("position", 32'h0, position);
    chk("direction", quadrature_decoder_pkg::DIR_REVERSE, direction);
    print_verdict();
  end
endmodule // quadrature_position_velocity_bench
`default_nettype wire
